// >>> design/cpu_datapath_pkg.sv
package cpu_datapath_pkg;

    // Word and field geometry
    localparam int WORD_W       = 18;
    localparam int LATCH_W      = 6;
    localparam int LATCH_LSB    = 12;       // Top six bits of the instruction word
    localparam int ADDR_FIELD_W = 13;
    localparam int TALLY_W      = 6;
    localparam int PAGE_SHIFT   = 8;        // Protect and relocate granule of 256 words
    localparam int STEP_LIM     = 8;        // Sign bit of the signed offset step field, bits 8:0
    localparam int LATCH_IND    = 1;        // Indirect flag position in the latch
    localparam int LATCH_IDX    = 0;        // Index flag position in the latch
    localparam int NORM_MAX     = 35;       // Normalize gives up when the tally reaches this count, after 36 shifts

    // Reset values
    localparam logic [17:0] WORD_RST  = 18'h00000;
    localparam logic [5:0]  LATCH_RST = 6'h00;
    localparam logic [5:0]  TALLY_RST = 6'h00;

    // Timing: figures in ns, counts rounded up to whole cycles
    localparam int CLK_PERIOD_NS    = 25;
    localparam int PROT_EXTRA_NS    = 30;
    localparam int USER_WR_EXTRA_NS = 175;
    localparam int PROT_EXTRA_CYC   = (PROT_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int USER_WR_CYC      = (USER_WR_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Commands accepted on the command port
    typedef enum logic [4:0] {
        OP_NOP      = 5'h00, OP_CLR_ACC = 5'h01, OP_CPL_ACC = 5'h02, OP_CLR_LNK = 5'h03,
        OP_CPL_LNK  = 5'h04, OP_ROT_L   = 5'h05, OP_ROT_R   = 5'h06, OP_ADD2    = 5'h07,
        OP_ADD1     = 5'h08, OP_AND     = 5'h09, OP_XOR     = 5'h0A, OP_OR_SW   = 5'h0B,
        OP_IO_IN    = 5'h0C, OP_IO_OUT  = 5'h0D, OP_LATCH   = 5'h0E, OP_EA      = 5'h0F,
        OP_LD_OFS   = 5'h10, OP_LD_BND  = 5'h11, OP_STEP    = 5'h12, OP_FETCH   = 5'h13,
        OP_MEM_RD   = 5'h14, OP_MEM_WR  = 5'h15, OP_JUMP    = 5'h16, OP_MUL     = 5'h17,
        OP_DIV      = 5'h18, OP_SHL     = 5'h19, OP_SHR     = 5'h1A, OP_NORM    = 5'h1B,
        OP_LD_PL    = 5'h1C, OP_PROT    = 5'h1D, OP_HALT    = 5'h1E, OP_EXEC    = 5'h1F
    } cmd_e;

    // Sub-selects of OP_PROT, in the operand low bits
    localparam logic [1:0] PROT_SEL_USER  = 2'h0;
    localparam logic [1:0] PROT_SEL_LOWER = 2'h1;
    localparam logic [1:0] PROT_SEL_RELOC = 2'h2;
    localparam logic [1:0] PROT_SEL_UPPER = 2'h3;

    // Sequencer states, Gray along idle -> stretch -> memory -> extended
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_MEM   = 2'b11,
        ST_EXT   = 2'b10
    } seq_e;

endpackage : cpu_datapath_pkg

// >>> design/cpu_register_datapath.sv
module cpu_register_datapath #(
    parameter int WORD_W = cpu_datapath_pkg::WORD_W
) (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    // Command port
    input  wire logic              cmd_valid_in,
    input  wire logic [4:0]        cmd_op_in,
    input  wire logic [17:0]       cmd_operand_in,
    output logic                   busy_out,
    // Installed options
    input  wire logic              ext_math_inst_in,
    input  wire logic              protect_inst_in,
    input  wire logic              relocate_inst_in,
    // Console switches, asynchronous
    input  wire logic [17:0]       switch_in,
    // Memory side
    input  wire logic              mem_ack_in,
    input  wire logic [17:0]       mem_rdata_in,
    output logic                   mem_req_out,
    output logic                   mem_we_out,
    output logic [17:0]            mem_addr_out,
    output logic [17:0]            store_buf_out,
    // Device transfer side
    input  wire logic [17:0]       io_rdata_in,
    output logic [17:0]            io_wdata_out,
    output logic                   io_strobe_out,
    // Register views and events
    output logic [17:0]            acc_out,
    output logic                   link_out,
    output logic [17:0]            pc_out,
    output logic [5:0]             opcode_latch_out,
    output logic [17:0]            eff_addr_out,
    output logic [17:0]            product_low_out,
    output logic [5:0]             step_tally_out,
    output logic                   skip_out,
    output logic                   user_mode_out,
    output logic                   trap_out,
    output logic                   halt_out
);

    typedef logic [WORD_W-1:0] word_t;

    cpu_datapath_pkg::seq_e seq_ff, nxt_seq;
    cpu_datapath_pkg::cmd_e op;
    cpu_datapath_pkg::cmd_e ext_op_ff;

    word_t      acc_ff, fetch_buf_ff, offset_ff, bound_ff, pl_ff;
    logic       link_ff;
    logic [5:0] tally_ff;
    logic [7:0] lower_pg_ff, reloc_pg_ff, upper_pg_ff;
    logic [3:0] wait_ff;
    logic       exec_chain_ff, fetch_pc_ff;
    word_t      sw_meta_ff, sw_sync_ff, sw_buf_ff;

    logic       take, illegal, priv, mem_op, mem_bad;
    word_t      vaddr, paddr;
    logic [18:0] sum2;
    word_t      sum1;
    logic       ovf1;
    word_t      step_ext, ofs_next;
    logic [18:0] mul_sum, div_diff;

    assign op   = cpu_datapath_pkg::cmd_e'(cmd_op_in);
    assign take = cmd_valid_in && (seq_ff == cpu_datapath_pkg::ST_IDLE);

    // Boundary check shared by every memory access
    function automatic logic addr_illegal(input word_t va, input logic [7:0] lo_pg,
                                          input logic [7:0] up_pg, input logic reloc_on);
        addr_illegal = (va[17:8] < {2'h0, lo_pg}) ||
                       (reloc_on && (va[17:8] >= {2'h0, up_pg}));
    endfunction : addr_illegal

    // Console switches are asynchronous: three stages before use
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sw_meta_ff <= cpu_datapath_pkg::WORD_RST;
            sw_sync_ff <= cpu_datapath_pkg::WORD_RST;
            sw_buf_ff  <= cpu_datapath_pkg::WORD_RST;
        end else begin
            sw_meta_ff <= switch_in;
            sw_sync_ff <= sw_meta_ff;
            sw_buf_ff  <= sw_sync_ff;                 // Console switch buffer
        end
    end

    // Shared adder paths
    always_comb begin
        sum2     = {link_ff, acc_ff} + {1'b0, fetch_buf_ff};
        sum1     = acc_ff + fetch_buf_ff + word_t'(sum2[18] ^ link_ff);          // End-around carry
        ovf1     = (acc_ff[17] == fetch_buf_ff[17]) && (sum1[17] != acc_ff[17]);
        step_ext = word_t'({{10{cmd_operand_in[8]}}, cmd_operand_in[8:0]});
        ofs_next = offset_ff + step_ext;
        mul_sum  = {1'b0, acc_ff} + {1'b0, fetch_buf_ff};
        div_diff = {acc_ff, pl_ff[17]} - {1'b0, fetch_buf_ff};
    end

    // Address for memory commands and its protection verdict
    always_comb begin
        mem_op  = (op == cpu_datapath_pkg::OP_FETCH) || (op == cpu_datapath_pkg::OP_MEM_RD) ||
                  (op == cpu_datapath_pkg::OP_MEM_WR);
        vaddr   = (op == cpu_datapath_pkg::OP_FETCH) ? pc_out : eff_addr_out;
        paddr   = user_mode_out && relocate_inst_in ?
                  vaddr + {2'h0, reloc_pg_ff, 8'h00} : vaddr;
        mem_bad = mem_op && addr_illegal(vaddr, lower_pg_ff, upper_pg_ff, relocate_inst_in);
        priv    = (op == cpu_datapath_pkg::OP_IO_IN) || (op == cpu_datapath_pkg::OP_IO_OUT) ||
                  (op == cpu_datapath_pkg::OP_HALT) || (op == cpu_datapath_pkg::OP_PROT) ||
                  ((op == cpu_datapath_pkg::OP_EXEC) && exec_chain_ff);
        illegal = protect_inst_in && user_mode_out && (priv || mem_bad);
    end

    // Sequencer: idle, protection stretch, memory handshake, extended steps
    always_comb begin
        nxt_seq = seq_ff;
        unique case (seq_ff)
            cpu_datapath_pkg::ST_IDLE: begin
                if (take && !illegal && mem_op) begin
                    nxt_seq = protect_inst_in ? cpu_datapath_pkg::ST_WAIT : cpu_datapath_pkg::ST_MEM;
                end else if (take && ext_math_inst_in &&
                             (op inside {cpu_datapath_pkg::OP_MUL, cpu_datapath_pkg::OP_DIV,
                                         cpu_datapath_pkg::OP_SHL, cpu_datapath_pkg::OP_SHR,
                                         cpu_datapath_pkg::OP_NORM})) begin
                    nxt_seq = cpu_datapath_pkg::ST_EXT;
                end
            end
            cpu_datapath_pkg::ST_WAIT: if (wait_ff == 4'h1) nxt_seq = cpu_datapath_pkg::ST_MEM;
            cpu_datapath_pkg::ST_MEM:  if (mem_ack_in) nxt_seq = cpu_datapath_pkg::ST_IDLE;
            cpu_datapath_pkg::ST_EXT: begin
                if ((ext_op_ff == cpu_datapath_pkg::OP_NORM) ?
                    ((acc_ff[17] != acc_ff[16]) || (tally_ff == 6'(cpu_datapath_pkg::NORM_MAX))) :
                    (tally_ff == 6'h01)) begin
                    nxt_seq = cpu_datapath_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) seq_ff <= cpu_datapath_pkg::ST_IDLE;
        else             seq_ff <= nxt_seq;
    end

    // Memory stretch counter and memory port; write stretch only in user mode
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_ff       <= 4'h0;
            mem_req_out   <= 1'b0;
            mem_we_out    <= 1'b0;
            mem_addr_out  <= cpu_datapath_pkg::WORD_RST;
            store_buf_out <= cpu_datapath_pkg::WORD_RST;
            fetch_pc_ff   <= 1'b0;
        end else begin
            if (seq_ff == cpu_datapath_pkg::ST_IDLE && nxt_seq != cpu_datapath_pkg::ST_IDLE && mem_op) begin
                wait_ff      <= 4'(cpu_datapath_pkg::PROT_EXTRA_CYC) +
                                ((user_mode_out && op == cpu_datapath_pkg::OP_MEM_WR) ?
                                 4'(cpu_datapath_pkg::USER_WR_CYC) : 4'h0);
                mem_req_out  <= !protect_inst_in;
                mem_we_out   <= (op == cpu_datapath_pkg::OP_MEM_WR);
                mem_addr_out <= paddr;
                fetch_pc_ff  <= (op == cpu_datapath_pkg::OP_FETCH);
                if (op == cpu_datapath_pkg::OP_MEM_WR) store_buf_out <= acc_ff;
            end else if (seq_ff == cpu_datapath_pkg::ST_WAIT) begin
                wait_ff     <= wait_ff - 4'h1;
                mem_req_out <= (wait_ff == 4'h1);
            end else if (seq_ff == cpu_datapath_pkg::ST_MEM && mem_ack_in) begin
                mem_req_out <= 1'b0;
                mem_we_out  <= 1'b0;
            end
        end
    end

    // Fetch buffer fills from memory independent of the result register
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) fetch_buf_ff <= cpu_datapath_pkg::WORD_RST;
        else if (seq_ff == cpu_datapath_pkg::ST_MEM && mem_ack_in && !mem_we_out) fetch_buf_ff <= mem_rdata_in;
    end

    // Program counter, opcode latch, effective pointer, offset and bound
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pc_out           <= cpu_datapath_pkg::WORD_RST;
            opcode_latch_out <= cpu_datapath_pkg::LATCH_RST;
            eff_addr_out     <= cpu_datapath_pkg::WORD_RST;
            offset_ff        <= cpu_datapath_pkg::WORD_RST;
            bound_ff         <= cpu_datapath_pkg::WORD_RST;
            skip_out         <= 1'b0;
        end else begin
            skip_out <= 1'b0;
            if (seq_ff == cpu_datapath_pkg::ST_MEM && mem_ack_in && fetch_pc_ff) begin
                pc_out <= pc_out + 18'h00001;
            end
            if (take && !illegal) begin
                unique case (op)
                    cpu_datapath_pkg::OP_LATCH:
                        opcode_latch_out <= fetch_buf_ff[17:cpu_datapath_pkg::LATCH_LSB];
                    cpu_datapath_pkg::OP_EA:
                        eff_addr_out <= opcode_latch_out[cpu_datapath_pkg::LATCH_IDX] ?
                                        offset_ff + word_t'(fetch_buf_ff[12:0]) :
                                        word_t'(fetch_buf_ff[12:0]);
                    cpu_datapath_pkg::OP_JUMP:   pc_out    <= cmd_operand_in;       // Extension bits replaced from the operand, all 18 bits loaded
                    cpu_datapath_pkg::OP_LD_OFS: offset_ff <= acc_ff;
                    cpu_datapath_pkg::OP_LD_BND: bound_ff  <= acc_ff;
                    cpu_datapath_pkg::OP_STEP: begin
                        offset_ff <= ofs_next;
                        if ($signed(ofs_next) >= $signed(bound_ff)) begin
                            pc_out   <= pc_out + 18'h00001;
                            skip_out <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Result register, link and product-low, single-cycle and stepped
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            acc_ff  <= cpu_datapath_pkg::WORD_RST;
            link_ff <= 1'b0;
            pl_ff   <= cpu_datapath_pkg::WORD_RST;
        end else if (seq_ff == cpu_datapath_pkg::ST_EXT) begin
            unique case (ext_op_ff)
                cpu_datapath_pkg::OP_MUL:
                    {link_ff, acc_ff, pl_ff} <= pl_ff[0] ? {1'b0, mul_sum, pl_ff[17:1]} :
                                                           {1'b0, 1'b0, acc_ff, pl_ff[17:1]};
                cpu_datapath_pkg::OP_DIV:
                    if (!div_diff[18]) {acc_ff, pl_ff} <= {div_diff[17:0], pl_ff[16:0], 1'b1};
                    else               {acc_ff, pl_ff} <= {acc_ff[16:0], pl_ff, 1'b0};
                cpu_datapath_pkg::OP_SHR:
                    {acc_ff, pl_ff} <= {link_ff, acc_ff, pl_ff[17:1]};
                default:
                    {acc_ff, pl_ff} <= {acc_ff[16:0], pl_ff, 1'b0};              // Shift left, normalize
            endcase
        end else if (take && !illegal) begin
            unique case (op)
                cpu_datapath_pkg::OP_CLR_ACC: acc_ff  <= cpu_datapath_pkg::WORD_RST;
                cpu_datapath_pkg::OP_CPL_ACC: acc_ff  <= ~acc_ff;
                cpu_datapath_pkg::OP_CLR_LNK: link_ff <= 1'b0;
                cpu_datapath_pkg::OP_CPL_LNK: link_ff <= ~link_ff;
                cpu_datapath_pkg::OP_ROT_L:   {link_ff, acc_ff} <= {acc_ff, link_ff};
                cpu_datapath_pkg::OP_ROT_R:   {link_ff, acc_ff} <= {acc_ff[0], link_ff, acc_ff[17:1]};
                cpu_datapath_pkg::OP_ADD2:    {link_ff, acc_ff} <= sum2;
                cpu_datapath_pkg::OP_ADD1: begin
                    acc_ff  <= sum1;
                    link_ff <= link_ff | ovf1;
                end
                cpu_datapath_pkg::OP_AND:     acc_ff <= acc_ff & fetch_buf_ff;
                cpu_datapath_pkg::OP_XOR:     acc_ff <= acc_ff ^ fetch_buf_ff;
                cpu_datapath_pkg::OP_OR_SW:   acc_ff <= acc_ff | sw_buf_ff;
                cpu_datapath_pkg::OP_IO_IN:   acc_ff <= io_rdata_in;
                cpu_datapath_pkg::OP_LD_PL:   pl_ff  <= acc_ff;
                cpu_datapath_pkg::OP_MUL:     if (ext_math_inst_in) acc_ff <= cpu_datapath_pkg::WORD_RST;
                default: ;
            endcase
        end
    end

    // Step tally: preload for counted ops, count up from zero on normalize
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tally_ff  <= cpu_datapath_pkg::TALLY_RST;
            ext_op_ff <= cpu_datapath_pkg::OP_NOP;
        end else if (seq_ff == cpu_datapath_pkg::ST_IDLE && nxt_seq == cpu_datapath_pkg::ST_EXT) begin
            ext_op_ff <= op;
            tally_ff  <= (op == cpu_datapath_pkg::OP_NORM) ? cpu_datapath_pkg::TALLY_RST :
                         cmd_operand_in[cpu_datapath_pkg::TALLY_W-1:0];
        end else if (seq_ff == cpu_datapath_pkg::ST_EXT) begin
            tally_ff  <= (ext_op_ff == cpu_datapath_pkg::OP_NORM) ? tally_ff + 6'h01 : tally_ff - 6'h01;
        end
    end

    // Protect and relocate state; a trap always returns to monitor mode
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            user_mode_out <= 1'b0;
            trap_out      <= 1'b0;
            lower_pg_ff   <= 8'h00;
            reloc_pg_ff   <= 8'h00;
            upper_pg_ff   <= 8'hFF;
            exec_chain_ff <= 1'b0;
        end else begin
            trap_out <= 1'b0;
            if (take) exec_chain_ff <= (op == cpu_datapath_pkg::OP_EXEC);
            if (take && illegal) begin
                trap_out      <= 1'b1;
                user_mode_out <= 1'b0;
            end else if (take && protect_inst_in && op == cpu_datapath_pkg::OP_PROT) begin
                unique case (cmd_operand_in[1:0])
                    cpu_datapath_pkg::PROT_SEL_USER:  user_mode_out <= 1'b1;
                    cpu_datapath_pkg::PROT_SEL_LOWER: lower_pg_ff <= acc_ff[7:0];
                    cpu_datapath_pkg::PROT_SEL_RELOC: reloc_pg_ff <= acc_ff[7:0];
                    cpu_datapath_pkg::PROT_SEL_UPPER: upper_pg_ff <= acc_ff[7:0];
                endcase
            end
        end
    end

    // Device transfer strobe and halt; outgoing word taken from the result register
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            io_wdata_out  <= cpu_datapath_pkg::WORD_RST;
            io_strobe_out <= 1'b0;
            halt_out      <= 1'b0;
        end else begin
            io_strobe_out <= take && !illegal && (op == cpu_datapath_pkg::OP_IO_OUT);
            if (take && !illegal && op == cpu_datapath_pkg::OP_IO_OUT) io_wdata_out <= acc_ff;
            if (take && !illegal && op == cpu_datapath_pkg::OP_HALT) halt_out <= 1'b1;
            else if (take) halt_out <= 1'b0;
        end
    end

    // Register views
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_out        <= 1'b0;
            acc_out         <= cpu_datapath_pkg::WORD_RST;
            link_out        <= 1'b0;
            product_low_out <= cpu_datapath_pkg::WORD_RST;
            step_tally_out  <= cpu_datapath_pkg::TALLY_RST;
        end else begin
            busy_out        <= (nxt_seq != cpu_datapath_pkg::ST_IDLE);
            acc_out         <= acc_ff;
            link_out        <= link_ff;
            product_low_out <= pl_ff;
            step_tally_out  <= tally_ff;
        end
    end

endmodule : cpu_register_datapath

// >>> bench/cpu_register_datapath_sva.sv
module cpu_register_datapath_sva (
    // Watched ports
    input wire logic        clk_in, reset_n_in, cmd_valid_in, busy_out, protect_inst_in,
    input wire logic [4:0]  cmd_op_in,
    input wire logic [17:0] cmd_operand_in, mem_addr_out,
    input wire logic        mem_ack_in, mem_req_out, mem_we_out, user_mode_out, trap_out, halt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // Takes decoded from the command port
    wire logic take = cmd_valid_in && !busy_out;
    wire logic rd_tk = take && cmd_op_in == 5'h14;
    wire logic ent_tk = take && cmd_op_in == 5'h1D && cmd_operand_in[1:0] == 2'h0;
    a_req_holds: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out)
        && $stable(mem_we_out)) else $error("memory request changed before ack");
    a_req_ends: assert property (mem_req_out && mem_ack_in |=> !mem_req_out)
        else $error("memory request kept after ack");
    a_read_prompt: assert property (rd_tk && !protect_inst_in |=> busy_out && mem_req_out)
        else $error("unstretched read late");
    a_read_stretch: assert property (rd_tk && protect_inst_in && !user_mode_out
        |=> !mem_req_out [*2] ##[1:3] mem_req_out) else $error("protected read not stretched");
    a_user_entry: assert property ($rose(user_mode_out) |-> $past(ent_tk) || $past(ent_tk, 2))
        else $error("user mode without entry command");
    a_trap_exits: assert property (trap_out |-> ##[0:1] !user_mode_out)
        else $error("user mode kept after trap");
    a_trap_source: assert property (trap_out |-> $past(user_mode_out) && $past(protect_inst_in))
        else $error("trap outside user mode");
    a_halt_monitor: assert property (take && cmd_op_in == 5'h1E && !user_mode_out |-> ##[1:2] halt_out)
        else $error("monitor halt not executed");
    a_halt_holds: assert property (halt_out && !take |=> halt_out)
        else $error("halt dropped without command");
endmodule : cpu_register_datapath_sva
bind cpu_register_datapath cpu_register_datapath_sva u_sva (.clk_in, .reset_n_in, .cmd_valid_in, .busy_out,
    .protect_inst_in, .cmd_op_in, .cmd_operand_in, .mem_addr_out, .mem_ack_in, .mem_req_out, .mem_we_out,
    .user_mode_out, .trap_out, .halt_out);

// >>> bench/mem_model.sv
module mem_model (
    // Memory side of the datapath
    input  wire logic        clk_in, reset_n_in, req_in,
    input  wire logic [17:0] word_in,
    output logic             ack_out,
    output logic [17:0]      rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Random wait per cycle; data is garbage outside a pending request
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_out <= 1'b0;
            rdata_out <= 18'h15555;
        end else begin
            ack_out <= req_in && !ack_out && ($urandom_range(2) == 0);
            rdata_out <= (req_in && !ack_out) ? word_in : ~rdata_out;
        end
    end
endmodule : mem_model

// >>> bench/cpu_register_datapath_test.sv
module cpu_register_datapath_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, reset_n_in = 1'b0, cmd_valid_in = 1'b0, ext_in = 1'b0, prot_in = 1'b0, rel_in = 1'b0;
    logic [4:0]  op = 5'h00;
    logic [17:0] operand = 18'h00000, sw = 18'h00000, io_d = 18'h00000, word = 18'h00000;
    logic [17:0] fb, acc, acc_v, rdata;
    logic        lnk, lnk_v, busy, ack, req, we, user, trap, halt, skip, stb, trap_seen = 1'b0;
    logic [17:0] pc, pl, io_w, sb, ofs, bnd, tgt, skips = 18'h00000, strobes = 18'h00000, exp_skips = 18'h00000;
    logic [5:0]  lat, tly;
    logic [35:0] prod;
    logic [4:0]  ops [9] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h06, 5'h09, 5'h0A, 5'h0B, 5'h0C};
    int          fails = 0, samples_checked = 0;
    always #12.5 clk_in = ~clk_in;
    // Pulses are caught and counted as they pass
    always @(posedge clk_in) begin
        if (trap === 1'b1) trap_seen <= 1'b1;
        skips <= skips + 18'(skip === 1'b1);
        strobes <= strobes + 18'(stb === 1'b1);
    end
    mem_model u_mem_model (.clk_in, .reset_n_in, .req_in(req), .word_in(word), .ack_out(ack), .rdata_out(rdata));
    cpu_register_datapath u_cpu_register_datapath (.clk_in, .reset_n_in, .cmd_valid_in, .cmd_op_in(op),
        .cmd_operand_in(operand), .busy_out(busy), .ext_math_inst_in(ext_in), .protect_inst_in(prot_in),
        .relocate_inst_in(rel_in), .switch_in(sw), .mem_ack_in(ack), .mem_rdata_in(rdata), .mem_req_out(req),
        .mem_we_out(we), .mem_addr_out(), .store_buf_out(sb), .io_rdata_in(io_d), .io_wdata_out(io_w),
        .io_strobe_out(stb), .acc_out(acc_v), .link_out(lnk_v), .pc_out(pc), .opcode_latch_out(lat),
        .eff_addr_out(), .product_low_out(pl), .step_tally_out(tly), .skip_out(skip), .user_mode_out(user),
        .trap_out(trap), .halt_out(halt));
    task print_verdict();
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One command, then a bounded wait for idle plus view lag
    task cmd(input logic [4:0] c);
        int i;
        @(posedge clk_in);
        op <= c;
        cmd_valid_in <= 1'b1;
        @(posedge clk_in);
        cmd_valid_in <= 1'b0;
        for (i = 0; i < 80 && (i < 3 || busy !== 1'b0); i++) @(posedge clk_in);
        @(posedge clk_in);                                   // Views lag the last step by one edge
        if (i == 80) begin
            fails++;
            print_verdict();
        end
    endtask : cmd
    // Expected link and result after a single-cycle command
    function logic [18:0] model(input logic [4:0] c, input logic l, input logic [17:0] a);
        case (c)
            5'h01: return {l, 18'h00000};
            5'h02: return {l, ~a};
            5'h04: return {~l, a};
            5'h05: return {a, l};
            5'h06: return {a[0], l, a[17:1]};
            5'h09: return {l, a & fb};
            5'h0A: return {l, a ^ fb};
            5'h0B: return {l, a | sw};
            default: return {l, io_d};
        endcase
    endfunction : model
    // One's complement sum with end-around carry; link flags overflow
    function logic [18:0] add1(input logic [17:0] a, input logic [17:0] b);
        logic [18:0] s;
        s = a + b;
        s[17:0] = s[17:0] + 18'(s[18]);
        return {(a[17] == b[17]) && (s[17] != a[17]), s[17:0]};
    endfunction : add1
    initial begin
        void'($urandom(32'h8021));
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        check("user_mode", {17'h0, user}, 18'h00000);
        acc = 18'h00000;
        for (int n = 0; n < 27; n++) begin
            fb = $urandom;
            word <= fb;
            sw <= $urandom;
            io_d <= $urandom;
            prot_in <= $urandom;
            rel_in <= $urandom;
            ext_in <= $urandom;
            cmd(5'h14);
            cmd(5'h07);
            acc = acc + fb;
            check("sum", acc_v, acc);
            cmd(5'h03);
            cmd(ops[n % 9]);
            {lnk, acc} = model(ops[n % 9], 1'b0, acc);
            check("result", acc_v, acc);
            check("link", {17'h0, lnk_v}, {17'h0, lnk});
        end
        prot_in <= 1'b0;
        ext_in <= 1'b1;
        for (int n = 0; n < 6; n++) begin
            fb = $urandom;
            word <= fb;
            io_d <= $urandom;
            cmd(5'h14);
            cmd(5'h0E);
            check("latch", {12'h0, lat}, {12'h0, fb[17:12]});
            cmd(5'h0C);
            cmd(5'h0D);
            check("io_out", io_w, io_d);
            cmd(5'h15);
            check("store", sb, io_d);
            cmd(5'h03);
            cmd(5'h08);
            {lnk, acc} = add1(io_d, fb);
            check("ones_sum", acc_v, acc);
            check("overflow", {17'h0, lnk_v}, {17'h0, lnk});
            cmd(5'h0C);
            cmd(5'h1C);
            operand <= 18'h00012;
            cmd(5'h17);
            prod = fb * io_d;
            check("product_low", pl, prod[17:0]);
            check("product_high", acc_v, prod[35:18]);
            check("tally", {12'h0, tly}, 18'h00000);
            ofs = $urandom;
            bnd = ofs + 18'($urandom_range(511)) - 18'h00100;
            io_d <= ofs;
            cmd(5'h0C);
            cmd(5'h10);
            io_d <= bnd;
            cmd(5'h0C);
            cmd(5'h11);
            operand <= 18'($urandom);
            cmd(5'h16);
            tgt = operand;
            operand <= 18'($urandom_range(511));
            cmd(5'h12);
            ofs = ofs + {{9{operand[8]}}, operand[8:0]};
            lnk = $signed(ofs) >= $signed(bnd);
            exp_skips = exp_skips + 18'(lnk);
            check("pc", pc, tgt + 18'(lnk));
        end
        check("skips", skips, exp_skips);
        check("strobes", strobes, 18'h00006);
        operand <= 18'h00000;
        prot_in <= 1'b1;
        cmd(5'h1D);
        check("user_mode", {17'h0, user}, 18'h00001);
        cmd(5'h1E);
        check("trap", {16'h0, trap_seen, user}, 18'h00002);
        cmd(5'h1E);
        check("halt", {17'h0, halt}, 18'h00001);
        print_verdict();
    end
endmodule : cpu_register_datapath_test
